// [verilog/idpm_pkg.sv]
`default_nettype none

package idpm_pkg;

  // ---------------------------------------------------------------
  // Idle domains
  // ---------------------------------------------------------------
  localparam int unsigned IDPM_NUM_DOMAINS = 6;
  localparam int unsigned IDPM_DOM_CORE = 0;
  localparam int unsigned IDPM_DOM_DMA = 1;
  localparam int unsigned IDPM_DOM_PERIPH = 2;
  localparam int unsigned IDPM_DOM_EXT_MEM_PORT = 3;
  localparam int unsigned IDPM_DOM_ICACHE = 4;
  localparam int unsigned IDPM_DOM_CLKGEN = 5;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int unsigned IDPM_ADDR_W = 8;
  localparam int unsigned IDPM_DATA_W = 32;
  localparam int unsigned IDPM_CNT_W = 32;

  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_DOM_EN = 8'h00;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_DOM_STAT = 8'h04;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_MEM_LP = 8'h08;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_PER_LP = 8'h0C;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_MEM_WAKES = 8'h10;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_PER_WAKES = 8'h14;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_MEM_LP_CYC = 8'h18;
  localparam logic [IDPM_ADDR_W-1:0] IDPM_OFF_PER_LP_CYC = 8'h1C;

  localparam logic [IDPM_NUM_DOMAINS-1:0] IDPM_DOM_EN_RESET = 6'h3F;
  localparam logic [IDPM_CNT_W-1:0] IDPM_CNT_RESET = 32'h0000_0000;
  localparam logic [IDPM_DATA_W-1:0] IDPM_RDATA_NONE = 32'h0000_0000;

  // Request from the register master, all signals of one cycle.
  typedef struct packed {
    logic [IDPM_ADDR_W-1:0] addr;
    logic [IDPM_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } idpm_bus_req_t;

  // Domain state as seen by one domain's gating logic.
  typedef enum logic [1:0] {
    IDPM_DOM_RUN,
    IDPM_DOM_IDLE,
    IDPM_DOM_RESTORE
  } idpm_dom_state_t;

endpackage : idpm_pkg

`default_nettype wire

// [verilog/idpm_unit_ctrl.sv]
`default_nettype none

module idpm_unit_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Activity of the unit
  input wire logic req,
  input wire logic done,
  input wire logic keep_awake,
  // Power state
  output logic low_power,
  output logic wake
);

  // ---------------------------------------------------------------
  // Access tracking
  // ---------------------------------------------------------------
  logic busy_reg;
  logic busy_next;
  logic was_lp_reg;
  logic was_lp_next;

  // An access that does not finish in its own cycle holds the unit awake.
  always_comb begin
    busy_next = busy_reg;
    if (req && !done) begin
      busy_next = 1'b1;
    end else if (done) begin
      busy_next = 1'b0;
    end
    was_lp_next = low_power;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      was_lp_reg <= 1'b1;
    end else begin
      busy_reg <= busy_next;
      was_lp_reg <= was_lp_next;
    end
  end

  // The request itself lifts low power in the same cycle, so no wait is added.
  assign low_power = !(req || busy_reg || keep_awake);
  assign wake = was_lp_reg && req;

endmodule : idpm_unit_ctrl

`default_nettype wire

// [verilog/idpm_power_manager.sv]
// Behaviour
// - Idle memory arrays sleep automatically.
// - Array request wakes it with no wait.
// - Array sleeps again once accesses end.
// - Inactive unneeded peripherals drop to low power.
// - Peripheral request wakes it without latency while the peripherals domain is enabled.
// - Automatic handling runs beside software domain idling.
// - Each idle domain has own enable.
// - Disabled domain idles keeping all contents.
// - Re-enabled domain resumes with retained state.
// - Six domains: core, DMA, peripherals, memport, cache, clockgen.
`default_nettype none

module idpm_power_manager
  import idpm_pkg::*;
#(
  parameter int unsigned N_MEM = 4,
  parameter int unsigned N_PER = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register bus
  input wire idpm_bus_req_t bus_req,
  output logic [IDPM_DATA_W-1:0] bus_rdata,
  // Memory arrays
  input wire logic [N_MEM-1:0] mem_req,
  input wire logic [N_MEM-1:0] mem_done,
  output logic [N_MEM-1:0] mem_grant,
  output logic [N_MEM-1:0] mem_low_power,
  // Peripherals
  input wire logic [N_PER-1:0] per_req,
  input wire logic [N_PER-1:0] per_done,
  input wire logic [N_PER-1:0] per_active,
  input wire logic [N_PER-1:0] per_need,
  output logic [N_PER-1:0] per_grant,
  output logic [N_PER-1:0] per_low_power,
  // Idle domains
  output logic [IDPM_NUM_DOMAINS-1:0] dom_clk_en,
  output logic [IDPM_NUM_DOMAINS-1:0] dom_retain,
  output logic [IDPM_NUM_DOMAINS-1:0] dom_restore
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (N_MEM < 1 || N_MEM > IDPM_DATA_W) begin : g_bad_mem
    $error("N_MEM must lie between 1 and the data width.");
  end
  if (N_PER < 1 || N_PER > IDPM_DATA_W) begin : g_bad_per
    $error("N_PER must lie between 1 and the data width.");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Saturating increment so a long-running count never wraps to zero.
  function automatic logic [IDPM_CNT_W-1:0] sat_inc(input logic [IDPM_CNT_W-1:0] value,
                                                     input logic step);
    logic [IDPM_CNT_W-1:0] result;
    result = value;
    if (step && (value != {IDPM_CNT_W{1'b1}})) begin
      result = value + 32'h0000_0001;
    end
    return result;
  endfunction : sat_inc

  // Zero-extends a vector of unit flags into a data word.
  function automatic logic [IDPM_DATA_W-1:0] widen(input logic [IDPM_DATA_W-1:0] bits,
                                                    input int unsigned count);
    logic [IDPM_DATA_W-1:0] result;
    result = IDPM_RDATA_NONE;
    for (int unsigned i = 0; i < IDPM_DATA_W; i++) begin
      if (i < count) begin
        result[i] = bits[i];
      end
    end
    return result;
  endfunction : widen

  // ---------------------------------------------------------------
  // Memory array automatic low power
  // ---------------------------------------------------------------
  logic [N_MEM-1:0] mem_wake;

  for (genvar m = 0; m < N_MEM; m++) begin : g_mem
    idpm_unit_ctrl u_mem_ctrl (
      .mclk(mclk),
      .reset_n(reset_n),
      .req(mem_req[m]),
      .done(mem_done[m]),
      .keep_awake(1'b0),
      .low_power(mem_low_power[m]),
      .wake(mem_wake[m])
    );
  end

  assign mem_grant = mem_req;

  // ---------------------------------------------------------------
  // Peripheral automatic low power
  // ---------------------------------------------------------------
  logic [N_PER-1:0] per_auto_lp;
  logic [N_PER-1:0] per_wake;
  logic periph_dom_idle;

  for (genvar p = 0; p < N_PER; p++) begin : g_per
    idpm_unit_ctrl u_per_ctrl (
      .mclk(mclk),
      .reset_n(reset_n),
      .req(per_req[p]),
      .done(per_done[p]),
      .keep_awake(per_active[p] || per_need[p]),
      .low_power(per_auto_lp[p]),
      .wake(per_wake[p])
    );
  end

  assign per_grant = per_req & {N_PER{!periph_dom_idle}};

  assign per_low_power = per_auto_lp | {N_PER{periph_dom_idle}};

  // ---------------------------------------------------------------
  // Idle domain control
  // ---------------------------------------------------------------
  logic [IDPM_NUM_DOMAINS-1:0] dom_en_reg;
  logic [IDPM_NUM_DOMAINS-1:0] dom_en_next;
  idpm_dom_state_t dom_state_reg [IDPM_NUM_DOMAINS];
  idpm_dom_state_t dom_state_next [IDPM_NUM_DOMAINS];
  logic [IDPM_NUM_DOMAINS-1:0] dom_idle;
  logic wr_dom_en;

  assign wr_dom_en = bus_req.wr && (bus_req.addr == IDPM_OFF_DOM_EN);

  always_comb begin
    dom_en_next = dom_en_reg;
    if (wr_dom_en) begin
      dom_en_next = bus_req.wdata[IDPM_NUM_DOMAINS-1:0];
    end
  end

  always_comb begin
    for (int unsigned d = 0; d < IDPM_NUM_DOMAINS; d++) begin
      dom_state_next[d] = dom_state_reg[d];
      case (dom_state_reg[d])
        IDPM_DOM_RUN: begin
          if (!dom_en_reg[d]) begin
            dom_state_next[d] = IDPM_DOM_IDLE;
          end
        end
        IDPM_DOM_IDLE: begin
          if (dom_en_reg[d]) begin
            dom_state_next[d] = IDPM_DOM_RESTORE;
          end
        end
        IDPM_DOM_RESTORE: begin
          if (dom_en_reg[d]) begin
            dom_state_next[d] = IDPM_DOM_RUN;
          end else begin
            dom_state_next[d] = IDPM_DOM_IDLE;
          end
        end
        default: begin
          dom_state_next[d] = IDPM_DOM_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dom_en_reg <= IDPM_DOM_EN_RESET;
      for (int unsigned d = 0; d < IDPM_NUM_DOMAINS; d++) begin
        dom_state_reg[d] <= IDPM_DOM_RUN;
      end
    end else begin
      dom_en_reg <= dom_en_next;
      for (int unsigned d = 0; d < IDPM_NUM_DOMAINS; d++) begin
        dom_state_reg[d] <= dom_state_next[d];
      end
    end
  end

  always_comb begin
    for (int unsigned d = 0; d < IDPM_NUM_DOMAINS; d++) begin
      dom_idle[d] = (dom_state_reg[d] == IDPM_DOM_IDLE);
      dom_restore[d] = (dom_state_reg[d] == IDPM_DOM_RESTORE);
    end
  end

  assign dom_clk_en = dom_en_reg;
  assign dom_retain = dom_idle;
  assign periph_dom_idle = !dom_en_reg[IDPM_DOM_PERIPH];

  // ---------------------------------------------------------------
  // Activity counters
  // ---------------------------------------------------------------
  logic [IDPM_CNT_W-1:0] mem_wakes_reg;
  logic [IDPM_CNT_W-1:0] mem_wakes_next;
  logic [IDPM_CNT_W-1:0] per_wakes_reg;
  logic [IDPM_CNT_W-1:0] per_wakes_next;
  logic [IDPM_CNT_W-1:0] mem_lp_cyc_reg;
  logic [IDPM_CNT_W-1:0] mem_lp_cyc_next;
  logic [IDPM_CNT_W-1:0] per_lp_cyc_reg;
  logic [IDPM_CNT_W-1:0] per_lp_cyc_next;

  // A write to a counter clears it; an event in that cycle counts from zero.
  always_comb begin
    mem_wakes_next = sat_inc(mem_wakes_reg, |mem_wake);
    per_wakes_next = sat_inc(per_wakes_reg, |per_wake);
    mem_lp_cyc_next = sat_inc(mem_lp_cyc_reg, &mem_low_power);
    per_lp_cyc_next = sat_inc(per_lp_cyc_reg, &per_low_power);
    if (bus_req.wr) begin
      case (bus_req.addr)
        IDPM_OFF_MEM_WAKES: begin
          mem_wakes_next = sat_inc(IDPM_CNT_RESET, |mem_wake);
        end
        IDPM_OFF_PER_WAKES: begin
          per_wakes_next = sat_inc(IDPM_CNT_RESET, |per_wake);
        end
        IDPM_OFF_MEM_LP_CYC: begin
          mem_lp_cyc_next = sat_inc(IDPM_CNT_RESET, &mem_low_power);
        end
        IDPM_OFF_PER_LP_CYC: begin
          per_lp_cyc_next = sat_inc(IDPM_CNT_RESET, &per_low_power);
        end
        default: begin
          mem_wakes_next = mem_wakes_next;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem_wakes_reg <= IDPM_CNT_RESET;
      per_wakes_reg <= IDPM_CNT_RESET;
      mem_lp_cyc_reg <= IDPM_CNT_RESET;
      per_lp_cyc_reg <= IDPM_CNT_RESET;
    end else begin
      mem_wakes_reg <= mem_wakes_next;
      per_wakes_reg <= per_wakes_next;
      mem_lp_cyc_reg <= mem_lp_cyc_next;
      per_lp_cyc_reg <= per_lp_cyc_next;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [IDPM_DATA_W-1:0] rdata_reg;
  logic [IDPM_DATA_W-1:0] rdata_next;
  logic [IDPM_DATA_W-1:0] mem_lp_word;
  logic [IDPM_DATA_W-1:0] per_lp_word;

  assign mem_lp_word = widen(IDPM_DATA_W'(mem_low_power), N_MEM);
  assign per_lp_word = widen(IDPM_DATA_W'(per_low_power), N_PER);

  // Read data stand only in the cycle after the read strobe.
  always_comb begin
    rdata_next = IDPM_RDATA_NONE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        IDPM_OFF_DOM_EN: begin
          rdata_next = IDPM_DATA_W'(dom_en_reg);
        end
        IDPM_OFF_DOM_STAT: begin
          rdata_next = IDPM_DATA_W'(dom_idle);
        end
        IDPM_OFF_MEM_LP: begin
          rdata_next = mem_lp_word;
        end
        IDPM_OFF_PER_LP: begin
          rdata_next = per_lp_word;
        end
        IDPM_OFF_MEM_WAKES: begin
          rdata_next = mem_wakes_reg;
        end
        IDPM_OFF_PER_WAKES: begin
          rdata_next = per_wakes_reg;
        end
        IDPM_OFF_MEM_LP_CYC: begin
          rdata_next = mem_lp_cyc_reg;
        end
        IDPM_OFF_PER_LP_CYC: begin
          rdata_next = per_lp_cyc_reg;
        end
        default: begin
          rdata_next = IDPM_RDATA_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_reg <= IDPM_RDATA_NONE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

endmodule : idpm_power_manager

`default_nettype wire

// [tb/idpm_power_manager_checker.sv]
`default_nettype none

module idpm_power_manager_checker
  import idpm_pkg::*;
#(
  parameter int unsigned N_MEM = 4,
  parameter int unsigned N_PER = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register bus
  input wire idpm_bus_req_t bus_req,
  input wire logic [IDPM_DATA_W-1:0] bus_rdata,
  // Memory arrays
  input wire logic [N_MEM-1:0] mem_req,
  input wire logic [N_MEM-1:0] mem_done,
  input wire logic [N_MEM-1:0] mem_grant,
  input wire logic [N_MEM-1:0] mem_low_power,
  // Peripherals
  input wire logic [N_PER-1:0] per_req,
  input wire logic [N_PER-1:0] per_done,
  input wire logic [N_PER-1:0] per_active,
  input wire logic [N_PER-1:0] per_need,
  input wire logic [N_PER-1:0] per_grant,
  input wire logic [N_PER-1:0] per_low_power,
  // Idle domains
  input wire logic [IDPM_NUM_DOMAINS-1:0] dom_clk_en,
  input wire logic [IDPM_NUM_DOMAINS-1:0] dom_retain,
  input wire logic [IDPM_NUM_DOMAINS-1:0] dom_restore
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  mem_stay_a: assert property (
    mem_low_power[0] && !mem_req[0] |=> mem_req[0] || mem_low_power[0])
    else $error("array woke without a request");
  mem_grant_a: assert property (
    mem_grant == mem_req && (mem_req & mem_low_power) == '0)
    else $error("array access delayed");
  mem_sleep_a: assert property (
    mem_done[0] && !mem_req[0] ##1 !mem_req[0] |-> mem_low_power[0])
    else $error("array stayed awake after access");
  per_idle_a: assert property (
    per_done[0] && !per_req[0] ##1 !(per_req[0] | per_active[0] | per_need[0])
    |-> per_low_power[0])
    else $error("idle peripheral stayed awake");
  per_wake_a: assert property (
    dom_clk_en[IDPM_DOM_PERIPH] |-> per_grant == per_req && (per_req & per_low_power) == '0)
    else $error("peripheral request delayed");
  per_gate_a: assert property (
    !dom_clk_en[IDPM_DOM_PERIPH] |-> per_grant == '0 && (&per_low_power))
    else $error("peripheral served in disabled domain");
  dom_write_a: assert property (
    bus_req.wr && bus_req.addr == IDPM_OFF_DOM_EN |=> dom_clk_en == $past(bus_req.wdata[5:0]))
    else $error("domain enables not taken from write");
  dom_retain_a: assert property (
    (~dom_clk_en & ~$past(dom_clk_en) & ~dom_retain) == '0)
    else $error("disabled domain not in retention");
  dom_restore_a: assert property (
    $rose(dom_clk_en[IDPM_DOM_CORE]) |=> dom_restore[0] && !dom_retain[0] ##1 !dom_restore[0])
    else $error("domain resume pulse wrong");
  stat_read_a: assert property (
    bus_req.rd && bus_req.addr == IDPM_OFF_DOM_STAT |=> bus_rdata == {26'h0, $past(dom_retain)})
    else $error("idle status read wrong");
endmodule : idpm_power_manager_checker

bind idpm_power_manager idpm_power_manager_checker #(.N_MEM(N_MEM), .N_PER(N_PER)) chk_u (
  .mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .mem_req(mem_req), .mem_done(mem_done), .mem_grant(mem_grant), .mem_low_power(mem_low_power),
  .per_req(per_req), .per_done(per_done), .per_active(per_active), .per_need(per_need),
  .per_grant(per_grant), .per_low_power(per_low_power), .dom_clk_en(dom_clk_en),
  .dom_retain(dom_retain), .dom_restore(dom_restore));

`default_nettype wire

// [tb/idpm_unit_model.sv]
`default_nettype none

module idpm_unit_model #(
  parameter int unsigned N = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Access side
  input wire logic slow,
  input wire logic [N-1:0] req,
  output logic [N-1:0] done,
  output logic [N-1:0] busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt [N];

  // Each unit finishes one cycle after the request, or three when slow.
  always @(posedge mclk) begin
    for (int i = 0; i < N; i++) begin
      if (!reset_n) begin
        cnt[i] <= 0;
      end else if (req[i]) begin
        cnt[i] <= slow ? 3 : 1;
      end else if (cnt[i] != 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      done[i] = (cnt[i] == 1);
      busy[i] = (cnt[i] != 0);
    end
  end
endmodule : idpm_unit_model

`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none

module tb_top
  import idpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, slow, run;
  idpm_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  logic [3:0] mem_req, mem_done, mem_grant, mem_low_power, mb, pb;
  logic [3:0] per_req, per_done, per_active, per_need, per_grant, per_low_power;
  logic [5:0] dom_clk_en, dom_retain, dom_restore, exp_en;
  logic [31:0] r;
  logic [3:0] mlp, plp, pexp;
  int mem_wakes_exp = 0;
  int per_wakes_exp = 0;
  integer seed = 12;
  int errors = 0;
  int check_count = 0;

  idpm_power_manager #(.N_MEM(4), .N_PER(4)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .mem_req(mem_req), .mem_done(mem_done),
    .mem_grant(mem_grant), .mem_low_power(mem_low_power), .per_req(per_req),
    .per_done(per_done), .per_active(per_active), .per_need(per_need),
    .per_grant(per_grant), .per_low_power(per_low_power), .dom_clk_en(dom_clk_en),
    .dom_retain(dom_retain), .dom_restore(dom_restore));
  idpm_unit_model #(.N(4)) mem_u (.mclk(mclk), .reset_n(reset_n), .slow(slow),
    .req(mem_req), .done(mem_done), .busy());
  idpm_unit_model #(.N(4)) per_u (.mclk(mclk), .reset_n(reset_n), .slow(slow),
    .req(per_req), .done(per_done), .busy(per_active));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // A write or a read with its expected data; starts and ends just after an edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    bus_req <= '0;
    if (w && a == IDPM_OFF_DOM_EN) exp_en = d[5:0];
    @(negedge mclk);
    if (!w) check(bus_rdata, d);
    @(posedge mclk);
  endtask : bus

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Traffic and reference model
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Requests go only to units the model sees idle, as a real requester would.
  always @(posedge mclk) begin
    if (!reset_n) begin
      mb = '0;
      pb = '0;
      mlp = 4'hF;
      plp = 4'hF;
      mem_wakes_exp = 0;
      per_wakes_exp = 0;
      exp_en = 6'h3F;
    end else begin
      // A wake is a request to a unit that sat in low power the cycle before.
      if (|(mem_req & mlp)) mem_wakes_exp++;
      if (|(per_req & plp)) per_wakes_exp++;
      mlp = ~(mem_req | mb);
      plp = ~(per_req | pb | per_active | per_need);
      mb = (mb | mem_req) & ~mem_done;
      pb = (pb | per_req) & ~per_done;
    end
    r = $random(seed);
    mem_req <= run ? r[3:0] & ~mb : 4'h0;
    per_req <= run ? r[7:4] & ~pb : 4'h0;
    per_need <= run ? r[11:8] & r[15:12] : 4'h0;
  end

  always @(negedge mclk) begin
    if (reset_n === 1'b1 && run) begin
      check({28'h0, mem_low_power}, {28'h0, ~(mem_req | mb)});
      check({28'h0, mem_grant}, {28'h0, mem_req});
      pexp = ~(per_req | pb | per_active | per_need) | {4{~exp_en[2]}};
      check({28'h0, per_low_power}, {28'h0, pexp});
      check({28'h0, per_grant}, {28'h0, per_req & {4{exp_en[2]}}});
      check({26'h0, dom_clk_en}, {26'h0, exp_en});
    end
  end

  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    slow = 1'b0;
    run = 1'b0;
    bus_req = '0;
    mem_req = '0;
    per_req = '0;
    per_need = '0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, IDPM_OFF_DOM_EN, 32'h3F);
    bus(1'b0, IDPM_OFF_DOM_STAT, 32'h0);
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b0, 8'h24, 32'h0);
    bus(1'b0, IDPM_OFF_DOM_EN, 32'h3F);
    run <= 1'b1;
    repeat (150) @(posedge mclk);
    slow <= 1'b1;
    repeat (150) @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, IDPM_OFF_DOM_EN, {26'h0, 6'h3F & ~(6'h1 << i)});
      repeat (2) @(posedge mclk);
      bus(1'b0, IDPM_OFF_DOM_STAT, {26'h0, 6'h1 << i});
      bus(1'b1, IDPM_OFF_DOM_EN, 32'h3F);
      repeat (3) @(posedge mclk);
      bus(1'b0, IDPM_OFF_DOM_STAT, 32'h0);
    end
    bus(1'b1, IDPM_OFF_DOM_EN, 32'h0);
    repeat (2) @(posedge mclk);
    bus(1'b0, IDPM_OFF_DOM_STAT, 32'h3F);
    bus(1'b1, IDPM_OFF_DOM_EN, 32'h05);
    repeat (40) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, IDPM_OFF_DOM_EN, 32'h3F);
    repeat (50) @(posedge mclk);
    run <= 1'b0;
    repeat (6) @(posedge mclk);
    bus(1'b0, IDPM_OFF_MEM_WAKES, mem_wakes_exp);
    bus(1'b0, IDPM_OFF_PER_WAKES, per_wakes_exp);
    bus(1'b0, IDPM_OFF_MEM_LP, 32'hF);
    bus(1'b0, IDPM_OFF_PER_LP, 32'hF);
    bus(1'b1, IDPM_OFF_MEM_LP_CYC, 32'h0);
    bus(1'b1, IDPM_OFF_PER_LP_CYC, 32'h0);
    bus(1'b0, IDPM_OFF_MEM_LP_CYC, 32'h4);
    bus(1'b0, IDPM_OFF_PER_LP_CYC, 32'h4);
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
